// ### include/lsp_pkg.sv
// lsp_pkg: constants, states and carrier types for the low-speed pin block.
// assumes: a single 25 MHz clock (mclk) drives every user of this package.
package lsp_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;
    // least low time on the reset pin that starts a full reset
    localparam int unsigned RESET_MIN_US = 2;
    localparam int unsigned RESET_MIN_CYCLES =
        (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest management init time after power-on, hot plug or reset release
    localparam int unsigned INIT_MAX_MS = 2000;
    localparam int unsigned INIT_MAX_CYCLES = (INIT_MAX_MS * 1000) / CLK_PERIOD_NS * 1000;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned PIN_W       = 5;
    localparam int unsigned PIN_SEL     = 0;
    localparam int unsigned PIN_RST     = 1;
    localparam int unsigned PIN_LPM     = 2;
    localparam int unsigned PIN_SCL     = 3;
    localparam int unsigned PIN_SDA     = 4;
    // all pins have pull-ups: idle level is high (deselected, not in reset)
    localparam logic [PIN_W-1:0] PIN_IDLE = 5'h1F;
    // flag bit that carries the reset-completion event
    localparam int unsigned FLAG_DONE   = 0;
    localparam int unsigned FLAG_W_DEF  = 4;

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LSP_INIT,
        LSP_READY,
        LSP_HOLD
    } lsp_state_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    // two-wire bus as seen by the internal management slave
    typedef struct packed {
        logic selected;
        logic scl;
        logic sda;
    } lsp_mgmt_bus_t;

    // state reported to the management slave's status bytes
    typedef struct packed {
        logic data_not_ready;
        logic settings_reset;
        logic low_power;
    } lsp_status_t;

endpackage

// ### rtl/lsp_pins.sv
// lsp_pins: low-speed control and status pin logic of a pluggable module end.
// assumes: pins arrive with pull-ups already resolved by the pads; an internal
// two-wire slave sits behind mgmt_bus and reports flag clears as pulses.
//
// Function
// - answer bus only while select is low
// - ignore all bus traffic while select high
// - long reset low restores all default settings
// - init interval starts at reset rising edge
// - completion shown by interrupt, not-ready cleared
// - post completion interrupt after power-up unprompted
// - low-power pin high enters reduced power
// - presence pin low while module inserted
// - interrupt low marks fault or critical status
// - interrupt pin only pulls low or floats
// - release interrupt promptly after clear-on-read
// - init completes within two thousand milliseconds
`timescale 1ns/1ps
`default_nettype none

module lsp_pins #(
    parameter int unsigned FLAG_W      = lsp_pkg::FLAG_W_DEF,
    parameter int unsigned RESET_MIN   = lsp_pkg::RESET_MIN_CYCLES,
    parameter int unsigned INIT_CYCLES = lsp_pkg::INIT_MAX_CYCLES
) (
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire logic                  module_select_pin_n,
    input  wire logic                  module_reset_n,
    input  wire logic                  low_power_request,
    input  wire logic                  scl,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe,
    output logic                       module_present_n,
    output logic                       interrupt_n_out,
    output logic                       interrupt_n_oe,
    input  wire logic                  slave_sda_oe,
    input  wire logic [FLAG_W-1:0]     flag_event,
    input  wire logic [FLAG_W-1:0]     flag_clear,
    output lsp_pkg::lsp_mgmt_bus_t     mgmt_bus,
    output lsp_pkg::lsp_status_t       status,
    output logic      [FLAG_W-1:0]     flags
);

    localparam int unsigned RST_CW  = $clog2(RESET_MIN + 1);
    localparam int unsigned INIT_CW = $clog2(INIT_CYCLES + 1);
    localparam logic [RST_CW-1:0]  RST_LAST  = RST_CW'(RESET_MIN);
    localparam logic [INIT_CW-1:0] INIT_LAST = INIT_CW'(INIT_CYCLES - 1);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [lsp_pkg::PIN_W-1:0] pins_sync;
    logic                      module_select_n;
    logic                      reset_pin_n;
    logic                      lpm_pin;

    // pads are asynchronous to mclk; idle value high means a floating select
    // reads as deselected until a real low has been sampled twice
    lsp_sync #(
        .WIDTH    (lsp_pkg::PIN_W),
        .IDLE     (lsp_pkg::PIN_IDLE)
    ) u_sync (
        .mclk     (mclk),
        .resetn   (resetn),
        .async_in ({sda_in, scl, low_power_request, module_reset_n, module_select_pin_n}),
        .sync_out (pins_sync)
    );

    assign module_select_n = pins_sync[lsp_pkg::PIN_SEL];
    assign reset_pin_n     = pins_sync[lsp_pkg::PIN_RST];
    assign lpm_pin         = pins_sync[lsp_pkg::PIN_LPM];

    // ------------------------------------------------------------------
    // module-select gating of the two-wire bus
    // ------------------------------------------------------------------
    // deselected: slave sees an idle bus (both lines high), so it never
    // decodes a start and cannot answer; the pad never pulls sda either
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mgmt_bus.selected <= 1'b0;
            mgmt_bus.scl      <= 1'b1;
            mgmt_bus.sda      <= 1'b1;
        end else begin
            mgmt_bus.selected <= !module_select_n;
            mgmt_bus.scl      <= module_select_n | pins_sync[lsp_pkg::PIN_SCL];
            mgmt_bus.sda      <= module_select_n | pins_sync[lsp_pkg::PIN_SDA];
        end
    end

    // sda is open-drain: output level is always low, only the enable moves
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe  <= slave_sda_oe & !module_select_n;
        end
    end

    // ------------------------------------------------------------------
    // reset pin: low-time qualification
    // ------------------------------------------------------------------
    logic [RST_CW-1:0] rst_low_count;
    logic              rst_qualified;

    // saturating count of cycles the pin has been low; glitches shorter
    // than the minimum pulse never reach the hold state
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rst_low_count <= '0;
        end else if (reset_pin_n) begin
            rst_low_count <= '0;
        end else if (rst_low_count != RST_LAST) begin
            rst_low_count <= rst_low_count + RST_CW'(1);
        end
    end

    assign rst_qualified = !reset_pin_n && (rst_low_count == RST_LAST);

    // ------------------------------------------------------------------
    // reset / init sequencer
    // ------------------------------------------------------------------
    lsp_pkg::lsp_state_t state;
    logic [INIT_CW-1:0]  init_count;
    logic                init_done;

    assign init_done = (state == lsp_pkg::LSP_INIT) && (init_count == INIT_LAST);

    // power-up lands in init, so completion is posted with no host pulse
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state <= lsp_pkg::LSP_INIT;
        end else begin
            case (state)
                lsp_pkg::LSP_INIT: begin
                    if (rst_qualified) begin
                        state <= lsp_pkg::LSP_HOLD;
                    end else if (init_done) begin
                        state <= lsp_pkg::LSP_READY;
                    end
                end
                lsp_pkg::LSP_READY: begin
                    if (rst_qualified) begin
                        state <= lsp_pkg::LSP_HOLD;
                    end
                end
                lsp_pkg::LSP_HOLD: begin
                    if (reset_pin_n) begin
                        state <= lsp_pkg::LSP_INIT;
                    end
                end
                default: begin
                    state <= lsp_pkg::LSP_INIT;
                end
            endcase
        end
    end

    // init timer runs only in init and restarts on every entry
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            init_count <= '0;
        end else if (state != lsp_pkg::LSP_INIT) begin
            init_count <= '0;
        end else if (!init_done) begin
            init_count <= init_count + INIT_CW'(1);
        end
    end

    // ------------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------------
    // settings_reset tells the management slave to reload defaults; it is
    // held for the whole qualified low time plus the first release cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            status.data_not_ready <= 1'b1;
            status.settings_reset <= 1'b1;
            status.low_power      <= 1'b1;
        end else begin
            status.data_not_ready <= !(init_done || state == lsp_pkg::LSP_READY) || rst_qualified;
            status.settings_reset <= rst_qualified || (state == lsp_pkg::LSP_HOLD);
            status.low_power      <= lpm_pin;
        end
    end

    // ------------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------------
    logic [FLAG_W-1:0] flag_set;

    // completion flag rises in the same cycle data_not_ready falls
    always_comb begin
        flag_set = flag_event;
        flag_set[lsp_pkg::FLAG_DONE] = flag_event[lsp_pkg::FLAG_DONE] | init_done;
    end

    // sticky flags, cleared on read; a set in the clear cycle wins, so an
    // event never slips between the host's read and the clear pulse
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            flags <= '0;
        end else if (rst_qualified || state == lsp_pkg::LSP_HOLD) begin
            flags <= '0;
        end else begin
            flags <= flag_set | (flags & ~flag_clear);
        end
    end

    // ------------------------------------------------------------------
    // interrupt and presence pins
    // ------------------------------------------------------------------
    // open collector: level fixed low, enable pulls; release one cycle after
    // the last clear, far inside the 500 us deassert limit
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            interrupt_n_out <= 1'b0;
            interrupt_n_oe  <= 1'b0;
        end else begin
            interrupt_n_out <= 1'b0;
            // follow the flag wipe of a full reset so the pin never lags the flags
            interrupt_n_oe  <= !(rst_qualified || state == lsp_pkg::LSP_HOLD)
                               && (|(flag_set | (flags & ~flag_clear)));
        end
    end

    // presence is a hard ground inside the module; host pull-up covers absence
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            module_present_n <= 1'b0;
        end else begin
            module_present_n <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### rtl/lsp_sync.sv
// lsp_sync: two-flop synchroniser for a group of asynchronous pins.
// assumes: inputs may change at any time; output is only read after stage two.
`timescale 1ns/1ps
`default_nettype none

module lsp_sync #(
    parameter int unsigned          WIDTH = 1,
    parameter logic [WIDTH-1:0]     IDLE  = '0
) (
    input  wire logic               mclk,
    input  wire logic               resetn,
    input  wire logic [WIDTH-1:0]   async_in,
    output logic      [WIDTH-1:0]   sync_out
);

    logic [WIDTH-1:0] meta;

    // ------------------------------------------------------------------
    // two stages, bit by bit
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // first stage feeds only the second one
            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    meta[i]     <= IDLE[i];
                    sync_out[i] <= IDLE[i];
                end else begin
                    meta[i]     <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ### sim/lsp_host_model.sv
// lsp_host_model: host board controller on the low-speed pins.
// assumes: tasks are called just after a rising edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module lsp_host_model (
    input  wire logic mclk,
    input  wire logic sda_oe,
    output wire logic select_pin_n,
    output logic      reset_n,
    output logic      lpm,
    output logic      scl,
    output wire logic sda
);
    logic sel_en;
    logic sel_lvl;
    logic sda_drv;
    // pull-ups: a released line reads high
    assign select_pin_n = sel_en ? sel_lvl : 1'b1;
    assign sda          = sda_drv & ~sda_oe;
    initial begin
        sel_en = 1'b0;
        sel_lvl = 1'b1;
        reset_n = 1'b1;
        lpm = 1'b0;
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic sel(input logic en, input logic lvl);
        sel_en = en;
        sel_lvl = lvl;
    endtask
    task automatic bus(input logic c, input logic d);
        scl = c;
        sda_drv = d;
    endtask
    task automatic set_lpm(input logic v);
        lpm = v;
    endtask
    // caller picks the low time; short holds are deliberate misuse
    task automatic hold_reset(input int n);
        reset_n = 1'b0;
        repeat (n) @(posedge mclk);
        #2;
        reset_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### sim/lsp_pins_asserts.sv
// lsp_pins_asserts: port-level timing checks of the low-speed pin block.
// assumes: bound onto lsp_pins; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module lsp_pins_asserts #(
    parameter int unsigned FLAG_W      = 4,
    parameter int unsigned RESET_MIN   = 50,
    parameter int unsigned INIT_CYCLES = 20
) (
    input wire logic                   mclk,
    input wire logic                   resetn,
    input wire logic                   module_select_pin_n,
    input wire logic                   module_reset_n,
    input wire logic                   low_power_request,
    input wire logic                   scl,
    input wire logic                   sda_in,
    input wire logic                   sda_out,
    input wire logic                   sda_oe,
    input wire logic                   module_present_n,
    input wire logic                   interrupt_n_out,
    input wire logic                   interrupt_n_oe,
    input wire logic                   slave_sda_oe,
    input wire logic [FLAG_W-1:0]      flag_event,
    input wire logic [FLAG_W-1:0]      flag_clear,
    input wire lsp_pkg::lsp_mgmt_bus_t mgmt_bus,
    input wire lsp_pkg::lsp_status_t   status,
    input wire logic [FLAG_W-1:0]      flags
);
    // --------
    // cycle counters: since reset, since pin release, pin low run
    // --------
    int unsigned age;
    int unsigned rel;
    int unsigned lo;
    // saturate so long runs never wrap
    always_ff @(posedge mclk) begin
        if (!resetn) age <= 0;
        else if (age < 8) age <= age + 1;
    end
    always_ff @(posedge mclk) begin
        if (!resetn || !module_reset_n) rel <= 0;
        else if (rel < INIT_CYCLES + 20) rel <= rel + 1;
    end
    always_ff @(posedge mclk) begin
        if (!resetn || module_reset_n) lo <= 0;
        else if (lo < RESET_MIN + 8) lo <= lo + 1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // --------
    // properties
    // --------
    AST_SEL_TRACK: assert property (age > 3 |-> mgmt_bus.selected == !$past(module_select_pin_n, 3))
        else $error("select gating off pin");
    AST_SDA_PASS: assert property (mgmt_bus.selected[*2] ##0 $past(slave_sda_oe) |-> sda_oe)
        else $error("sda drive lost while selected");
    AST_DESEL_IDLE: assert property (!mgmt_bus.selected |-> mgmt_bus.scl && mgmt_bus.sda)
        else $error("bus seen while deselected");
    AST_DESEL_OE: assert property (!mgmt_bus.selected [*2] |-> !sda_oe)
        else $error("sda driven while deselected");
    AST_RST_HOLD: assert property (lo >= RESET_MIN + 4 |-> status.settings_reset && status.data_not_ready && flags == '0)
        else $error("long reset low not applied");
    AST_INIT_START: assert property ($fell(status.data_not_ready) |-> rel >= INIT_CYCLES)
        else $error("init ended too early");
    AST_INIT_BOUND: assert property (rel > INIT_CYCLES + 10 |-> !status.data_not_ready)
        else $error("init overran");
    AST_DONE_POST: assert property ($fell(status.data_not_ready) |-> flags[lsp_pkg::FLAG_DONE] && interrupt_n_oe)
        else $error("completion not posted");
    AST_INT_OR: assert property (interrupt_n_oe == (|flags))
        else $error("interrupt not OR of flags");
    AST_FLAG_CLR: assert property (flag_clear[1] && !flag_event[1] |=> !flags[1])
        else $error("flag not released");
    AST_OPEN_DRAIN: assert property (interrupt_n_out == 1'b0 && sda_out == 1'b0)
        else $error("open-drain pin driven high");
    AST_PRESENT: assert property (module_present_n == 1'b0)
        else $error("presence not low");
    AST_LPM: assert property (age > 3 |-> status.low_power == $past(low_power_request, 3))
        else $error("low power not followed");
endmodule
bind lsp_pins lsp_pins_asserts #(.FLAG_W(FLAG_W), .RESET_MIN(RESET_MIN), .INIT_CYCLES(INIT_CYCLES)) u_chk (
    .mclk(mclk), .resetn(resetn), .module_select_pin_n(module_select_pin_n), .module_reset_n(module_reset_n),
    .low_power_request(low_power_request), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .module_present_n(module_present_n), .interrupt_n_out(interrupt_n_out), .interrupt_n_oe(interrupt_n_oe),
    .slave_sda_oe(slave_sda_oe), .flag_event(flag_event), .flag_clear(flag_clear), .mgmt_bus(mgmt_bus),
    .status(status), .flags(flags));
`default_nettype wire

// ### sim/test_lsp_pins.sv
// test_lsp_pins: self-checking bench for the low-speed pin block.
// assumes: short reset and init counts; bench plays the internal slave.
`timescale 1ns/1ps
`default_nettype none
module test_lsp_pins;
    localparam int unsigned RMIN = 4;
    localparam int unsigned INIT = 20;
    logic                   mclk;
    logic                   resetn;
    logic                   slave_oe;
    logic [3:0]             ev;
    logic [3:0]             clr;
    wire logic              sel_n;
    wire logic              rst_n;
    wire logic              lpm;
    wire logic              scl;
    wire logic              sda;
    logic                   sda_out;
    logic                   sda_oe;
    logic                   present_n;
    logic                   int_out;
    logic                   int_oe;
    lsp_pkg::lsp_mgmt_bus_t mbus;
    lsp_pkg::lsp_status_t   st;
    logic [3:0]             flags;
    int                     n_fail;
    int                     samples_checked;
    // host pull-up on the interrupt line
    wire logic int_line = int_oe ? int_out : 1'b1;
    lsp_host_model host (.mclk(mclk), .sda_oe(sda_oe), .select_pin_n(sel_n), .reset_n(rst_n), .lpm(lpm),
        .scl(scl), .sda(sda));
    lsp_pins #(.FLAG_W(4), .RESET_MIN(RMIN), .INIT_CYCLES(INIT)) dut (.mclk(mclk), .resetn(resetn),
        .module_select_pin_n(sel_n), .module_reset_n(rst_n), .low_power_request(lpm), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .module_present_n(present_n), .interrupt_n_out(int_out),
        .interrupt_n_oe(int_oe), .slave_sda_oe(slave_oe), .flag_event(ev), .flag_clear(clr), .mgmt_bus(mbus),
        .status(st), .flags(flags));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // --------
    // helpers
    // --------
    task automatic tally_and_finish();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // status is not trusted until the interrupt line drops
    task automatic wait_int(output int n);
        n = 0;
        while (int_line !== 1'b0 && n < INIT + 40) begin
            tick(1);
            n++;
        end
        if (int_line !== 1'b0) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic clear_flag(input int b);
        clr[b] = 1'b1;
        tick(1);
        clr[b] = 1'b0;
    endtask
    // --------
    // scenarios
    // --------
    task automatic s_powerup();
        int n;
        wait_int(n);
        chk({st.data_not_ready, st.settings_reset, flags}, 8'h01);
        chk({present_n, int_out}, 8'h00);
        clear_flag(0);
        chk({flags, int_line}, 8'h01);
    endtask
    // selected, driven high, selected, released
    task automatic s_select();
        host.bus(1'b0, 1'b0);
        slave_oe = 1'b1;
        for (int i = 0; i < 4; i++) begin
            host.sel(i != 3, i[0]);
            tick(5);
            chk({mbus.selected, sda_oe}, i[0] ? 8'h00 : 8'h03);
            chk({mbus.scl, mbus.sda}, i[0] ? 8'h03 : 8'h00);
        end
        slave_oe = 1'b0;
        host.bus(1'b1, 1'b1);
    endtask
    task automatic s_short_reset();
        host.hold_reset(RMIN - 2);
        tick(8);
        chk({st.settings_reset, st.data_not_ready, int_line}, 8'h01);
    endtask
    // a raised fault flag must be wiped by the full reset
    task automatic s_long_reset();
        int n;
        ev[2] = 1'b1;
        tick(1);
        ev[2] = 1'b0;
        host.hold_reset(RMIN + 6);
        chk({st.settings_reset, st.data_not_ready, flags}, 8'h30);
        wait_int(n);
        chk(n >= INIT, 1'b1);
        chk({st.settings_reset, st.data_not_ready, flags}, 8'h01);
        clear_flag(0);
    endtask
    task automatic s_flags();
        for (int b = 1; b < 4; b++) begin
            ev[b] = 1'b1;
            tick(1);
            ev[b] = 1'b0;
            chk({flags[b], int_line}, 8'h02);
            tick(3);
            clear_flag(b);
            chk({flags, int_line}, 8'h01);
        end
        // set and clear in one cycle: set wins
        ev[1] = 1'b1;
        clr[1] = 1'b1;
        tick(1);
        ev[1] = 1'b0;
        clr[1] = 1'b0;
        chk({flags, int_line}, 8'h04);
        clear_flag(1);
    endtask
    task automatic s_lpm();
        for (int v = 1; v >= 0; v--) begin
            host.set_lpm(v[0]);
            tick(4);
            chk(st.low_power, v[0]);
        end
    endtask
    initial begin
        resetn = 1'b0;
        slave_oe = 1'b0;
        ev = 4'h0;
        clr = 4'h0;
        n_fail = 0;
        samples_checked = 0;
        tick(12);
        resetn = 1'b1;
        s_powerup();
        s_select();
        s_short_reset();
        s_long_reset();
        s_flags();
        s_lpm();
        tally_and_finish();
    end
endmodule
`default_nettype wire
